// ### flush_engine.sv
`timescale 1ns/1ps
module flush_engine
  import lookup_ctrl_pkg::*;
#(
  parameter int N = NUM_PORTS
)
(
  input  wire logic    clk,          // Core clock.
  input  wire logic    rst_b,        // Asynchronous reset, active low.
  flush_if.eng         fl,           // Requests and completions.
  output logic         flushReq_r,   // Flush command to the table, held till done.
  output flush_kind_t  flushKind_r,  // What the flush covers.
  output logic [1:0]   flushScope_r, // Dynamic, static or both.
  output logic [PORT_W-1:0] flushPort_r, // Port for a link-down flush.
  input  wire logic    flushDone     // Table finished the flush.
);

  typedef enum {ST_IDLE, ST_RUN} eng_st_t;
  eng_st_t st_r;

  logic             anyPort;
  logic [PORT_W-1:0] portSel;
  flush_kind_t      pickKind;
  logic [1:0]       pickScope;
  logic             pickAny;
  logic             skipNow;
  logic             runDone;

  // Lowest numbered port with a pending link-down flush.
  always_comb begin
    portSel = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (fl.reqPort[i]) begin
        portSel = PORT_W'(i);
      end
    end
  end

  // Whole-table flush first, then instance flush, then port flushes.
  assign anyPort   = |fl.reqPort;
  assign pickAny   = fl.reqAll || fl.reqMstp || anyPort;
  assign pickKind  = fl.reqAll ? FLUSH_ALL : (fl.reqMstp ? FLUSH_MSTP : FLUSH_PORT);
  assign pickScope = (pickKind == FLUSH_PORT) ? FOPT_BOTH : fl.scope;
  assign skipNow   = (st_r == ST_IDLE) && pickAny && (pickScope == FOPT_NONE);
  assign runDone   = (st_r == ST_RUN) && flushDone;

  // Completions are combinational so a request is never picked twice.
  assign fl.doneAll  = (runDone && flushKind_r == FLUSH_ALL) || (skipNow && pickKind == FLUSH_ALL);
  assign fl.doneMstp = (runDone && flushKind_r == FLUSH_MSTP)
                    || (skipNow && pickKind == FLUSH_MSTP);
  assign fl.donePort = (runDone && flushKind_r == FLUSH_PORT) ? (N'(1) << flushPort_r) : '0;

  // Issue one flush and hold it until the table reports completion.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r         <= ST_IDLE;
      flushReq_r   <= 1'b0;
      flushKind_r  <= FLUSH_ALL;
      flushScope_r <= FOPT_NONE;
      flushPort_r  <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (pickAny && !skipNow) begin
            st_r         <= ST_RUN;
            flushReq_r   <= 1'b1;
            flushKind_r  <= pickKind;
            flushScope_r <= pickScope;
            flushPort_r  <= portSel;
          end
        end
        ST_RUN: begin
          if (flushDone) begin
            st_r       <= ST_IDLE;
            flushReq_r <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule // flush_engine

// ### flush_if.sv
`timescale 1ns/1ps
// Flush requests from the register bank and completions from the sequencer.
interface flush_if #(parameter int N = 7);
  logic         reqAll;
  logic         reqMstp;
  logic [N-1:0] reqPort;
  logic [1:0]   scope;
  logic         doneAll;
  logic         doneMstp;
  logic [N-1:0] donePort;
  modport ctrl (output reqAll, reqMstp, reqPort, scope, input doneAll, doneMstp, donePort);
  modport eng  (input reqAll, reqMstp, reqPort, scope, output doneAll, doneMstp, donePort);
endinterface // flush_if

// ### frame_screen.sv
`timescale 1ns/1ps
module frame_screen
  import lookup_ctrl_pkg::*;
(
  input  wire logic             clk,          // Core clock.
  input  wire logic             rst_b,        // Asynchronous reset, active low.
  input  wire logic             frmValid,     // Source address valid pulse.
  input  wire logic [MAC_W-1:0] srcAddr,      // Received source address.
  input  wire logic [MAC_W-1:0] selfMac,      // Own switch address.
  input  wire logic             filterEn,     // Global and port filter enable.
  input  wire logic             mcastFwd,     // Forward multicast sources.
  input  wire logic             learnDis,     // Unicast learning disable.
  output logic                  verdict_r,    // Verdict valid pulse.
  output logic                  drop_r,       // Drop the frame.
  output logic                  learn_r       // Learn the source address.
);

  logic isSelf;
  logic isMcast;
  logic dropNow;

  // Multicast sources are never learned, whatever the learning bit says.
  assign isSelf  = filterEn && (srcAddr == selfMac);
  assign isMcast = srcAddr[MULTICAST_BIT];
  assign dropNow = isSelf || (isMcast && !mcastFwd);

  // One verdict per source address, one cycle after it arrives.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      verdict_r <= 1'b0;
      drop_r    <= 1'b0;
      learn_r   <= 1'b0;
    end else begin
      verdict_r <= frmValid;
      drop_r    <= frmValid && dropNow;
      learn_r   <= frmValid && !dropNow && !isMcast && !learnDis;
    end
  end

  chk_learn_off: assert property (@(posedge clk) disable iff (!rst_b)
    learn_r |-> $past(!learnDis))
    else $error("Address learned while learning disabled.");

  chk_self_drop: assert property (@(posedge clk) disable iff (!rst_b)
    $past(frmValid && filterEn && srcAddr == selfMac) |-> verdict_r && drop_r)
    else $error("Self-addressed frame not dropped.");

  chk_drop_cause: assert property (@(posedge clk) disable iff (!rst_b)
    drop_r |-> $past(filterEn && srcAddr == selfMac) || $past(!mcastFwd && isMcast))
    else $error("Frame dropped without filter cause.");

  chk_mcast_drop: assert property (@(posedge clk) disable iff (!rst_b)
    $past(frmValid && isMcast) |-> (drop_r == $past(!mcastFwd || isSelf)))
    else $error("Multicast source verdict wrong.");

endmodule // frame_screen

// ### lookup_ctrl_pkg.sv
package lookup_ctrl_pkg;

  // Port count and field widths.
  localparam int NUM_PORTS = 7;
  localparam int PORT_W    = 3;
  localparam int MSTI_W    = 4;
  localparam int ADDR_W    = 12;
  localparam int MAC_W     = 48;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CTRL1  = 10'h311;
  localparam logic [9:0] IDX_CTRL2  = 10'h312;
  localparam logic [9:0] IDX_MSTP   = 10'h320;
  localparam logic [9:0] IDX_STATUS = 10'h321;

  // Control 1 field positions.
  localparam int BIT_LEARN_DIS = 7;
  localparam int BIT_SAF_GLOB  = 6;
  localparam int BIT_FLUSH_ALL = 5;
  localparam int BIT_FLUSH_MST = 4;
  localparam int BIT_MCAST_FWD = 3;
  localparam int BIT_AGING_EN  = 2;
  localparam int BIT_FAST_AGE  = 1;
  localparam int BIT_LDN_FLUSH = 0;

  // Control 2 flush option field position, status busy bit and source address multicast bit.
  localparam int FOPT_LSB        = 2;
  localparam int BIT_STAT_BUSY   = 8;
  localparam int MULTICAST_BIT   = 40;

  // Reset values.
  localparam logic [7:0] CTRL1_RESET = 8'h0c;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [MSTI_W-1:0] MSTP_RESET = 4'h0;

  // Flush option codes.
  localparam logic [1:0] FOPT_NONE = 2'h0;
  localparam logic [1:0] FOPT_DYN  = 2'h1;
  localparam logic [1:0] FOPT_STAT = 2'h2;
  localparam logic [1:0] FOPT_BOTH = 2'h3;

  // What a flush removes: the whole table, one spanning-tree instance or one port.
  typedef enum logic [1:0] {FLUSH_ALL, FLUSH_MSTP, FLUSH_PORT} flush_kind_t;

  // Aging tick timing.
  localparam int CLK_NS           = 50;
  localparam int AGE_TICK_NORM_US = 1000000;
  localparam int AGE_TICK_FAST_US = 1000;
  localparam int AGE_NORM_CYC     = AGE_TICK_NORM_US / CLK_NS * 1000;
  localparam int AGE_FAST_CYC     = AGE_TICK_FAST_US / CLK_NS * 1000;
  localparam int AGE_CNT_W        = 25;

endpackage

// ### lookup_engine_ctrl.sv
`timescale 1ns/1ps
// Function
// - Bit 7 set stops unicast source learning.
// - Drop frames whose source equals own address.
// - Filter only when global and port enabled.
// - Bit 5 starts whole-table flush, self-clearing.
// - Bit 4 flushes matched spanning-tree entries.
// - Flush option field limits flushed entry types.
// - Option 01 dynamic, 10 static, 11 both.
// - Bit 3 clear drops multicast-source frames.
// - Bit 2 set enables aging of entries.
// - Bit 1 set selects fast aging.
// - Bit 0 set flushes ports on link loss.
module lookup_engine_ctrl
  import lookup_ctrl_pkg::*;
#(
  parameter int N            = NUM_PORTS,    // Switch ports.
  parameter int AGE_NORM_LEN = AGE_NORM_CYC, // Cycles between normal aging ticks.
  parameter int AGE_FAST_LEN = AGE_FAST_CYC  // Cycles between fast aging ticks.
)
(
  input  wire logic              clk,          // Core clock, 20 MHz.
  input  wire logic              rst_b,        // Asynchronous reset, active low.
  input  wire logic              hsel,         // AHB slave select.
  input  wire logic [ADDR_W-1:0] haddr,        // AHB byte address.
  input  wire logic [1:0]        htrans,       // AHB transfer type.
  input  wire logic              hwrite,       // AHB write strobe.
  input  wire logic [2:0]        hsize,        // AHB transfer size.
  input  wire logic [31:0]       hwdata,       // AHB write data.
  input  wire logic              hready,       // AHB bus ready.
  output logic                   hreadyout,    // Slave ready, always high.
  output logic                   hresp,        // Slave response, always OKAY.
  output logic [31:0]            hrdata,       // AHB read data.
  input  wire logic [MAC_W-1:0]  selfMac,      // Own switch address.
  input  wire logic [N-1:0]      portSafEn,    // Per-port self filter enables.
  input  wire logic [N-1:0]      linkUp,       // Port link state pins.
  input  wire logic [N-1:0]      frmValid,     // Source address valid pulses.
  input  wire logic [N*MAC_W-1:0] srcAddr,     // Source addresses, port 0 lowest.
  output logic [N-1:0]           verdictValid, // Verdict valid pulses.
  output logic [N-1:0]           frmDrop,      // Drop decisions.
  output logic [N-1:0]           frmLearn,     // Learn decisions.
  output logic                   flushReq,     // Flush command, held till done.
  output flush_kind_t            flushKind,    // Flush coverage.
  output logic [1:0]             flushScope,   // Entry types to remove.
  output logic [PORT_W-1:0]      flushPort,    // Port of a link-down flush.
  output logic [MSTI_W-1:0]      flushInst,    // Selected spanning-tree instance.
  input  wire logic              flushDone,    // Table finished the flush.
  output logic                   ageTick,      // Aging step pulse.
  output logic                   agingOn,      // Aging enabled level.
  output logic                   ageFast       // Fast aging selected level.
);

  // Byte addresses of the registers and the limits of the aging divider.
  localparam logic [ADDR_W-1:0] ADDR_CTRL1  = {IDX_CTRL1, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL2  = {IDX_CTRL2, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MSTP   = {IDX_MSTP, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [AGE_CNT_W-1:0] NORM_LIM = AGE_CNT_W'(AGE_NORM_LEN - 1);
  localparam logic [AGE_CNT_W-1:0] FAST_LIM = AGE_CNT_W'(AGE_FAST_LEN - 1);

  // Requests and completions between the register bank and the sequencer.
  flush_if #(.N(N)) fl ();

  logic              busWr_r;
  logic [ADDR_W-1:0] busAddr_r;
  logic [7:0]        ctrl1_r;
  logic [7:0]        ctrl2_r;
  logic [MSTI_W-1:0] mstp_r;
  logic              allPend_r;
  logic              mstpPend_r;
  logic [N-1:0]      portPend_r;
  logic [N-1:0]      linkS1_r;
  logic [N-1:0]      linkS2_r;
  logic [N-1:0]      linkS3_r;
  logic [N-1:0]      linkSt_r;
  logic [AGE_CNT_W-1:0] ageCnt_r;
  logic              ageTick_r;
  logic [31:0]       hrdata_r;

  logic        addrTake;
  logic        wrCtrl1;
  logic        wrCtrl2;
  logic        wrMstp;
  logic [7:0]  ctrl1Rd;
  logic [31:0] rdMux;
  logic [31:0] statusRd;
  logic [N-1:0] linkFall;
  logic [N-1:0] filtEn;
  logic        allPend_nxt;
  logic        mstpPend_nxt;
  logic [N-1:0] portPend_nxt;
  logic [AGE_CNT_W-1:0] ageLim;
  logic        ageWrap;

  // Zero wait states: every transfer completes with OKAY in one data phase.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign addrTake  = hsel && hready && htrans[1];

  // Writes land in the data phase, when hwdata is on the bus.
  assign wrCtrl1 = busWr_r && (busAddr_r == ADDR_CTRL1);
  assign wrCtrl2 = busWr_r && (busAddr_r == ADDR_CTRL2);
  assign wrMstp  = busWr_r && (busAddr_r == ADDR_MSTP);

  // Flush bits show the pending request rather than stored data.
  assign ctrl1Rd = {ctrl1_r[7:6], allPend_r, mstpPend_r, ctrl1_r[3:0]};
  assign statusRd = {{(31 - BIT_STAT_BUSY){1'b0}}, flushReq, {(BIT_STAT_BUSY - N){1'b0}}, linkSt_r};

  // Read selection; an unmapped address reads as zero.
  assign rdMux = (haddr == ADDR_CTRL1)  ? {24'h000000, ctrl1Rd} :
                 (haddr == ADDR_CTRL2)  ? {24'h000000, ctrl2_r} :
                 (haddr == ADDR_MSTP)   ? {{(32 - MSTI_W){1'b0}}, mstp_r} :
                 (haddr == ADDR_STATUS) ? statusRd : 32'h00000000;

  // Bus address phase capture and read data register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busWr_r   <= 1'b0;
      busAddr_r <= '0;
      hrdata_r  <= 32'h00000000;
    end else begin
      busWr_r <= addrTake && hwrite;
      if (addrTake) begin
        busAddr_r <= haddr;
      end
      if (addrTake && !hwrite) begin
        hrdata_r <= rdMux;
      end
    end
  end

  // Control registers; flush bits are never stored here.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl1_r <= CTRL1_RESET;
      ctrl2_r <= CTRL2_RESET;
      mstp_r  <= MSTP_RESET;
    end else begin
      if (wrCtrl1) begin
        ctrl1_r <= {hwdata[7:6], 2'b00, hwdata[3:0]};
      end
      if (wrCtrl2) begin
        ctrl2_r <= hwdata[7:0];
      end
      if (wrMstp) begin
        mstp_r <= hwdata[MSTI_W-1:0];
      end
    end
  end

  // Link pins pass three flops; a change counts when the last two agree.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkS1_r <= '0;
      linkS2_r <= '0;
      linkS3_r <= '0;
      linkSt_r <= '0;
    end else begin
      linkS1_r <= linkUp;
      linkS2_r <= linkS1_r;
      linkS3_r <= linkS2_r;
      linkSt_r <= (linkS2_r & linkS3_r) | (linkSt_r & (linkS2_r | linkS3_r));
    end
  end

  // A link that was up and now reads low twice in a row has been lost.
  assign linkFall = linkSt_r & ~linkS2_r & ~linkS3_r;

  // Pending flushes: a new request in the completing cycle wins over the clear.
  assign allPend_nxt  = (allPend_r && !fl.doneAll) || (wrCtrl1 && hwdata[BIT_FLUSH_ALL]);
  assign mstpPend_nxt = (mstpPend_r && !fl.doneMstp)
                     || (wrCtrl1 && hwdata[BIT_FLUSH_MST]);
  assign portPend_nxt = (portPend_r & ~fl.donePort)
                     | (linkFall & {N{ctrl1_r[BIT_LDN_FLUSH]}});

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      allPend_r  <= 1'b0;
      mstpPend_r <= 1'b0;
      portPend_r <= '0;
    end else begin
      allPend_r  <= allPend_nxt;
      mstpPend_r <= mstpPend_nxt;
      portPend_r <= portPend_nxt;
    end
  end

  // The option field scopes both software flushes.
  assign fl.reqAll  = allPend_r;
  assign fl.reqMstp = mstpPend_r;
  assign fl.reqPort = portPend_r;
  assign fl.scope   = ctrl2_r[FOPT_LSB +: 2];
  assign flushInst  = mstp_r;

  flush_engine #(.N(N)) u_flush (
    .clk          (clk),
    .rst_b        (rst_b),
    .fl           (fl.eng),
    .flushReq_r   (flushReq),
    .flushKind_r  (flushKind),
    .flushScope_r (flushScope),
    .flushPort_r  (flushPort),
    .flushDone    (flushDone)
  );

  // Aging steps come from a divider whose period follows the fast bit.
  assign agingOn = ctrl1_r[BIT_AGING_EN];
  assign ageFast = ctrl1_r[BIT_FAST_AGE];
  assign ageLim  = ageFast ? FAST_LIM : NORM_LIM;
  assign ageWrap = ageCnt_r >= ageLim;
  assign ageTick = ageTick_r;

  // Switching to fast aging mid-count wraps at the fast limit, at once if already past it, rather than waiting out the old period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ageCnt_r  <= '0;
      ageTick_r <= 1'b0;
    end else if (!agingOn) begin
      ageCnt_r  <= '0;
      ageTick_r <= 1'b0;
    end else begin
      ageCnt_r  <= ageWrap ? '0 : ageCnt_r + 1'b1;
      ageTick_r <= ageWrap;
    end
  end

  // One screening unit per port; the port enable gates the global one.
  assign filtEn = portSafEn & {N{ctrl1_r[BIT_SAF_GLOB]}};

  for (genvar p = 0; p < N; p++) begin : g_port
    frame_screen u_screen (
      .clk       (clk),
      .rst_b     (rst_b),
      .frmValid  (frmValid[p]),
      .srcAddr   (srcAddr[p*MAC_W +: MAC_W]),
      .selfMac   (selfMac),
      .filterEn  (filtEn[p]),
      .mcastFwd  (ctrl1_r[BIT_MCAST_FWD]),
      .learnDis  (ctrl1_r[BIT_LEARN_DIS]),
      .verdict_r (verdictValid[p]),
      .drop_r    (frmDrop[p]),
      .learn_r   (frmLearn[p])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_flush_all_set: assert property (
    wrCtrl1 && hwdata[BIT_FLUSH_ALL] |=> allPend_r ##0 ctrl1Rd[BIT_FLUSH_ALL])
    else $error("Table flush request lost.");

  chk_flush_mstp_set: assert property (
    wrCtrl1 && hwdata[BIT_FLUSH_MST] |=> mstpPend_r)
    else $error("Instance flush request lost.");

  chk_flush_hold: assert property (
    allPend_r && !fl.doneAll |=> allPend_r)
    else $error("Flush bit cleared before completion.");

  chk_flush_zero_write: assert property (
    !allPend_r && !(wrCtrl1 && hwdata[BIT_FLUSH_ALL]) |=> !allPend_r)
    else $error("Flush bit set without a one written.");

  chk_scope_used: assert property (
    $rose(flushReq) && flushKind != FLUSH_PORT |-> flushScope == $past(fl.scope)
      && flushScope != FOPT_NONE)
    else $error("Flush issued with wrong scope.");

  chk_age_off: assert property (
    !agingOn |=> !ageTick [*2])
    else $error("Aging tick while aging disabled.");

  chk_age_fast: assert property (
    ageTick && $past(ageFast) && $past(ageFast, 2) |-> $past(ageCnt_r) == FAST_LIM)
    else $error("Fast aging period wrong.");

  chk_link_flush: assert property (
    (linkFall != '0) && ctrl1_r[BIT_LDN_FLUSH] |=> (portPend_r != '0) || flushReq)
    else $error("Link loss did not queue a flush.");

  // A link-down flush always removes both entry types.
  chk_port_scope: assert property (
    $rose(flushReq) && flushKind == FLUSH_PORT |-> flushScope == FOPT_BOTH)
    else $error("Port flush not scoped to both types.");

  // The table relies on the command fields holding still during a flush.
  chk_cmd_stable: assert property (
    flushReq && $past(flushReq) |-> $stable(flushKind) && $stable(flushScope)
      && $stable(flushPort))
    else $error("Flush command changed while held.");

  // The command drops one cycle after the table reports completion.
  chk_flush_release: assert property (
    flushReq && flushDone |=> !flushReq)
    else $error("Flush command held after completion.");

  // A whole-table request outranks every other pending flush.
  chk_all_first: assert property (
    $rose(flushReq) && $past(allPend_r) |-> flushKind == FLUSH_ALL)
    else $error("Table flush not issued first.");

  chk_mstp_kind: assert property (
    $rose(flushReq) && !$past(allPend_r) && $past(mstpPend_r) |-> flushKind == FLUSH_MSTP)
    else $error("Instance flush issued with wrong kind.");

  // With option 00 a table request completes at once and never reaches the table.
  chk_none_skip: assert property (
    allPend_r && !flushReq && fl.scope == FOPT_NONE && !wrCtrl1 |=> !allPend_r)
    else $error("Table flush with option 00 not dropped.");

  // With link-down flush off a lost link queues nothing.
  chk_link_quiet: assert property (
    (linkFall != '0) && !ctrl1_r[BIT_LDN_FLUSH] && (portPend_r == '0) |=> portPend_r == '0)
    else $error("Link loss queued a flush while disabled.");

  // A normal tick only follows the counter reaching the long limit.
  chk_age_norm: assert property (
    ageTick && !$past(ageFast) && !$past(ageFast, 2) |-> $past(ageCnt_r) == NORM_LIM)
    else $error("Normal aging period wrong.");

  cov_flush_done: cover property ($rose(flushReq) ##[1:20] flushDone);
  cov_frame_drop: cover property (verdictValid != '0 && frmDrop != '0);
  cov_link_fall:  cover property (linkFall != '0 && ctrl1_r[BIT_LDN_FLUSH]);
  cov_age_tick:   cover property (ageTick && ageFast);
  cov_mstp_flush: cover property ($rose(flushReq) && flushKind == FLUSH_MSTP);

endmodule // lookup_engine_ctrl

// ### test_lookup_engine_ctrl.sv
`timescale 1ns/1ps
module test_lookup_engine_ctrl;
  import lookup_ctrl_pkg::*;

  localparam int NLEN = 40;
  localparam int FLEN = 8;
  localparam logic [ADDR_W-1:0] A_C1   = 12'hc44;
  localparam logic [ADDR_W-1:0] A_C2   = 12'hc48;
  localparam logic [ADDR_W-1:0] A_INST = 12'hc80;
  localparam logic [ADDR_W-1:0] A_STAT = 12'hc84;
  localparam logic [ADDR_W-1:0] A_GAP  = 12'hc40;
  localparam logic [MAC_W-1:0]  SELF   = 48'h020000000001;
  localparam logic [MAC_W-1:0]  OTHER  = 48'h020000000777;
  localparam logic [MAC_W-1:0]  MCAST  = 48'h010000000005;

  typedef struct {logic [7:0] ctrl; logic [6:0] en; logic [47:0] src; logic drop; logic learn;} row_t;

  logic                       clk, rst_b, hsel, hwrite, hreadyout, hresp, flushReq, flushDone;
  logic                       ageTick, agingOn, ageFast;
  logic [ADDR_W-1:0]          haddr;
  logic [1:0]                 htrans, flushScope;
  logic [2:0]                 hsize;
  logic [31:0]                hwdata, hrdata, rd;
  logic [MAC_W-1:0]           selfMac;
  logic [NUM_PORTS-1:0]       portSafEn, linkUp, frmValid, verdictValid, frmDrop, frmLearn;
  logic [NUM_PORTS*MAC_W-1:0] srcAddr;
  logic [PORT_W-1:0]          flushPort;
  logic [MSTI_W-1:0]          flushInst;
  flush_kind_t                flushKind;
  int                         errorCnt, nTests, gap;

  // Ordinary frame cases: control value, port enables, source, expected drop and learn.
  row_t rows [7] = '{'{8'h0c, 7'h7f, SELF, 1'b0, 1'b1}, '{8'h4c, 7'h7f, SELF, 1'b1, 1'b0},
                     '{8'h4c, 7'h7b, SELF, 1'b0, 1'b1}, '{8'h8c, 7'h7f, OTHER, 1'b0, 1'b0},
                     '{8'h0c, 7'h7f, MCAST, 1'b0, 1'b0}, '{8'h04, 7'h7f, MCAST, 1'b1, 1'b0},
                     '{8'h0a, 7'h7f, OTHER, 1'b0, 1'b1}};

  // The only slave's ready output is the bus ready.
  lookup_engine_ctrl #(.AGE_NORM_LEN(NLEN), .AGE_FAST_LEN(FLEN)) lookup_engine_ctrl_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .selfMac(selfMac), .portSafEn(portSafEn), .linkUp(linkUp),
    .frmValid(frmValid), .srcAddr(srcAddr), .verdictValid(verdictValid), .frmDrop(frmDrop),
    .frmLearn(frmLearn), .flushReq(flushReq), .flushKind(flushKind), .flushScope(flushScope),
    .flushPort(flushPort), .flushInst(flushInst), .flushDone(flushDone), .ageTick(ageTick),
    .agingOn(agingOn), .ageFast(ageFast));

  // Free-running core clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compares one result; four-state inequality so an unknown never matches.
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A wait that ran out of bound counts as a mismatch and closes the run.
  task automatic timeout(input string what);
    errorCnt++;
    $display("[FAIL] %s expected event seen timeout", what);
    summarize();
  endtask

  // One AHB single transfer; the master waits on hreadyout and never assumes a latency.
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) timeout("address phase");
    htrans <= 2'h0;
    hwdata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) timeout("data phase");
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // Bounded wait for the flush command to reach a level.
  task automatic waitFlush(input logic lvl);
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      #1;
      if (flushReq === lvl) break;
    end
    if (i == 60) timeout("flushReq");
  endtask

  // Table side finishing a flush with a one-cycle completion.
  task automatic doneP;
    @(posedge clk);
    flushDone <= 1'b1;
    @(posedge clk);
    flushDone <= 1'b0;
    waitFlush(1'b0);
  endtask

  // No flush command may appear for ten cycles.
  task automatic noFlush;
    repeat (10) begin
      @(posedge clk);
      #1;
      chk("no flush", 48'h0, flushReq);
    end
  endtask

  // Cycles from one aging tick to the next; 200 means none seen.
  task automatic ageGap(output int g);
    int i;
    g = 0;
    for (i = 0; i < 200 && ageTick !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    do begin
      @(posedge clk);
      #1;
      g++;
    end while (ageTick !== 1'b1 && g < 200);
  endtask

  task automatic resetDut;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
  endtask

  // Main sequence: reset, table of frame cases, then aging, flushes and a second reset.
  initial begin
    int o, t;
    logic [7:0] bitv;
    errorCnt = 0;
    nTests = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwrite = 1'b0;
    hwdata = '0;
    selfMac = SELF;
    portSafEn = '1;
    linkUp = '1;
    frmValid = '0;
    srcAddr = '0;
    flushDone = 1'b0;
    resetDut();
    chk("agingOn reset", 48'h1, agingOn);
    chk("ageFast reset", 48'h0, ageFast);
    rdc("ctrl1 reset", A_C1, 32'h0c);
    rdc("ctrl2 reset", A_C2, 32'h00);
    wr(A_GAP, 32'h5a);
    rdc("unmapped", A_GAP, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 7; r++) begin
      wr(A_C1, {24'h0, rows[r].ctrl});
      portSafEn <= rows[r].en;
      rdc("ctrl1 readback", A_C1, {24'h0, rows[r].ctrl});
      @(posedge clk);
      frmValid <= 7'h04;
      srcAddr[2*MAC_W +: MAC_W] <= rows[r].src;
      @(posedge clk);
      frmValid <= '0;
      #1;
      chk("verdict", 48'h04, verdictValid);
      chk("drop", rows[r].drop, frmDrop[2]);
      chk("learn", rows[r].learn, frmLearn[2]);
      chk("agingOn", rows[r].ctrl[2], agingOn);
      chk("ageFast", rows[r].ctrl[1], ageFast);
    end
    $display("test frame table done");
    wr(A_C1, 32'h0c);
    ageGap(gap);
    ageGap(gap);
    chk("normal aging gap", NLEN, gap);
    wr(A_C1, 32'h0e);
    ageGap(gap);
    ageGap(gap);
    chk("fast aging gap", FLEN, gap);
    wr(A_C1, 32'h0a);
    ageGap(gap);
    chk("aging off", 48'd200, gap);
    $display("test aging done");
    wr(A_INST, 32'h9);
    rdc("inst readback", A_INST, 32'h9);
    for (o = 1; o < 4; o++) begin
      for (t = 0; t < 2; t++) begin
        bitv = (t == 1) ? 8'h10 : 8'h20;
        wr(A_C2, 32'(o << 2));
        wr(A_C1, {24'h0, 8'h0c | bitv});
        rdc("flush pending", A_C1, {24'h0, 8'h0c | bitv});
        waitFlush(1'b1);
        chk("flushKind", (t == 1) ? FLUSH_MSTP : FLUSH_ALL, flushKind);
        chk("flushScope", o, flushScope);
        chk("flushInst", 48'h9, flushInst);
        wr(A_C1, 32'h0c);
        rdc("write zero", A_C1, {24'h0, 8'h0c | bitv});
        doneP();
        rdc("flush cleared", A_C1, 32'h0c);
      end
    end
    wr(A_C2, 32'h0);
    wr(A_C1, 32'h2c);
    noFlush();
    rdc("option none", A_C1, 32'h0c);
    $display("test flush done");
    wr(A_C1, 32'h0d);
    linkUp <= 7'h77;
    waitFlush(1'b1);
    chk("link kind", FLUSH_PORT, flushKind);
    chk("link port", 48'h3, flushPort);
    chk("link scope", 48'h3, flushScope);
    rdc("link status", A_STAT, 32'h177);
    doneP();
    wr(A_C1, 32'h0c);
    linkUp <= 7'h67;
    noFlush();
    $display("test link down done");
    wr(A_C1, 32'h80);
    resetDut();
    rdc("ctrl1 second reset", A_C1, 32'h0c);
    $display("test second reset done");
    summarize();
  end

endmodule // test_lookup_engine_ctrl
